// >>> rtl/seq_pkg.sv
package seq_pkg;
    localparam int CLK_MHZ = 125;
    localparam int CLK_NS = 8;
    // times in ns, except DEG_MS in ms and HOLD_US in us
    localparam int CLIP_DLY_NS = 3000;
    localparam int REQ_ON_NS = 25600;
    localparam int REQ_OFF_NS = 25000;
    localparam int PUP_DEG_NS = 12000;
    localparam int PUP_RUN_NS = 32000;
    localparam int HALF_MIN_NS = 280;
    localparam int HALF_MAX_NS = 32000;
    localparam int DIP_NS = 100000;
    localparam int DEG_MS = 110;
    localparam int HOLD_US = 3300;
    localparam int PROBE_GOOD_CYCLES = 4;
    // least times round up, longest round down
    localparam int CLIP_CYC = (CLIP_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int REQ_ON_CYC = (REQ_ON_NS + CLK_NS - 1) / CLK_NS;
    localparam int REQ_OFF_CYC = (REQ_OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int PUP_DEG_CYC = (PUP_DEG_NS + CLK_NS - 1) / CLK_NS;
    localparam int PUP_RUN_CYC = (PUP_RUN_NS + CLK_NS - 1) / CLK_NS;
    localparam int HALF_MIN_CYC = (HALF_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int HALF_MAX_CYC = HALF_MAX_NS / CLK_NS;
    localparam int DIP_CYC = DIP_NS / CLK_NS;
    localparam int DEG_CYC = DEG_MS * 1000 * CLK_MHZ;
    localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
    localparam int CNT_W = 24;
    typedef enum logic [2:0] {
        ST_OFF, ST_PUP, ST_DEG, ST_HOLD, ST_PROBE, ST_RUN
    } seq_state_t;
endpackage

// >>> rtl/level_timer.sv
`timescale 1ns/1ns
`default_nettype none
// output rises once input has stayed high for LIMIT cycles, falls at once
module level_timer
    import seq_pkg::*;
#(
    parameter int LIMIT = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // level in, qualified level out
    input wire logic level,
    output logic held
);
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (!level) begin
            cnt_r <= '0;
        end else if (cnt_r < CNT_W'(LIMIT)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign held = level && (cnt_r >= CNT_W'(LIMIT));
endmodule
`default_nettype wire

// >>> rtl/degauss_powerup_fault_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module degauss_powerup_fault_sequencer
    import seq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins and comparators
    input wire logic demag_req,
    input wire logic main_supply_ok,
    input wire logic main_supply_crit,
    input wire logic probe_cmp,
    input wire logic amp_not_linear,
    // control outputs
    output logic coil_drive_en,
    output logic probe_osc_en,
    output logic degauss_active,
    output logic overload_recover_en,
    // open-drain flags, enable high pulls low
    output logic fault_n_o,
    output logic fault_n_oe,
    output logic clip_n_o,
    output logic clip_n_oe
);
    // ------------------------------
    // synchronisers
    // ------------------------------
    logic [4:0] s1_r, s2_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= {demag_req, main_supply_ok, main_supply_crit, probe_cmp, amp_not_linear};
            s2_r <= s1_r;
        end
    end
    logic req, sup_ok, sup_crit, pcmp, over;
    assign req = s2_r[4];
    assign sup_ok = s2_r[3];
    assign sup_crit = s2_r[2];
    assign pcmp = s2_r[1];
    assign over = s2_r[0];

    // ------------------------------
    // filters
    // ------------------------------
    logic clip_hit, req_on, req_off, dip_long;
    level_timer #(.LIMIT(CLIP_CYC)) u_clip (
        .clk(clk), .rst(rst), .level(over), .held(clip_hit));
    level_timer #(.LIMIT(REQ_ON_CYC)) u_on (
        .clk(clk), .rst(rst), .level(req), .held(req_on));
    level_timer #(.LIMIT(REQ_OFF_CYC)) u_off (
        .clk(clk), .rst(rst), .level(!req), .held(req_off));
    level_timer #(.LIMIT(DIP_CYC)) u_dip (
        .clk(clk), .rst(rst), .level(!sup_ok), .held(dip_long));

    // ------------------------------
    // probe watch
    // ------------------------------
    logic pcmp_d_r;
    logic [CNT_W-1:0] half_r;
    logic [2:0] good_r;
    logic probe_dead_r, stuck_seen_r;
    logic edge_seen;
    seq_state_t st_r, st_nxt;
    assign edge_seen = pcmp != pcmp_d_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pcmp_d_r <= 1'b0;
            half_r <= '0;
        end else begin
            pcmp_d_r <= pcmp;
            if (edge_seen) half_r <= '0;
            else if (half_r < CNT_W'(HALF_MAX_CYC)) half_r <= half_r + 1'b1;
        end
    end

    // counts good half-periods; eight make four full cycles
    logic [3:0] good_half_r;
    logic half_ok, half_bad;
    assign half_ok = edge_seen && half_r >= CNT_W'(HALF_MIN_CYC);
    assign half_bad = (edge_seen && half_r < CNT_W'(HALF_MIN_CYC))
        || half_r >= CNT_W'(HALF_MAX_CYC);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            good_half_r <= '0;
        end else if (half_bad || !probe_osc_en || st_r == ST_PUP) begin
            good_half_r <= '0;
        end else if (half_ok && good_half_r < 4'(2 * PROBE_GOOD_CYCLES)) begin
            good_half_r <= good_half_r + 1'b1;
        end
    end
    assign good_r = 3'(good_half_r >> 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            probe_dead_r <= 1'b0;
        end else begin
            probe_dead_r <= half_r >= CNT_W'(HALF_MAX_CYC) && !pcmp;
        end
    end

    // remembers an interrupted probe loop until hold finishes
    logic hold_done;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stuck_seen_r <= 1'b0;
        end else if (probe_dead_r && st_r != ST_OFF && st_r != ST_PUP) begin
            stuck_seen_r <= 1'b1;
        end else if (hold_done || st_r == ST_OFF) begin
            // a full restart is the normal path, so recovery may resume
            stuck_seen_r <= 1'b0;
        end
    end

    // ------------------------------
    // sequencer
    // ------------------------------
    logic [CNT_W-1:0] tmr_r;
    logic por;
    // hazard: brown-out lasting long or critical dip restarts everything
    assign por = sup_crit || dip_long || !sup_ok && st_r == ST_OFF;
    assign hold_done = st_r == ST_HOLD && tmr_r >= CNT_W'(HOLD_CYC);

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_OFF: if (sup_ok && !sup_crit) st_nxt = ST_PUP;
            ST_PUP: begin
                if (req && tmr_r >= CNT_W'(PUP_DEG_CYC)) st_nxt = ST_DEG;
                else if (!req && tmr_r >= CNT_W'(PUP_RUN_CYC)) st_nxt = ST_PROBE;
            end
            ST_DEG: begin
                if (req_off) st_nxt = ST_HOLD;
                else if (tmr_r >= CNT_W'(DEG_CYC)) st_nxt = ST_PROBE;
            end
            ST_HOLD: if (hold_done) st_nxt = ST_PROBE;
            ST_PROBE: begin
                if (good_r >= 3'(PROBE_GOOD_CYCLES)) st_nxt = ST_RUN;
                else if (req_on) st_nxt = ST_DEG;
            end
            ST_RUN: begin
                if (probe_dead_r) st_nxt = ST_HOLD;
                else if (req_on) st_nxt = ST_DEG;
            end
            default: st_nxt = ST_OFF;
        endcase
        if (por) st_nxt = ST_OFF;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmr_r <= '0;
        end else if (st_nxt != st_r || (st_r == ST_HOLD && probe_dead_r)) begin
            // hold counts from probe recovery, not from the fault
            tmr_r <= '0;
        end else if (tmr_r < CNT_W'(DEG_CYC)) begin
            tmr_r <= tmr_r + 1'b1;
        end
    end

    // ------------------------------
    // outputs
    // ------------------------------
    logic fault_r, clip_r, coil_r, deg_r, osc_r, ovr_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_r <= 1'b1;
            clip_r <= 1'b0;
            coil_r <= 1'b0;
            deg_r <= 1'b0;
            osc_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            // a short dip with live probe passes unflagged
            fault_r <= st_nxt != ST_RUN || probe_dead_r;
            clip_r <= clip_hit;
            coil_r <= st_nxt == ST_RUN || st_nxt == ST_DEG;
            deg_r <= st_nxt == ST_DEG;
            osc_r <= st_nxt != ST_OFF;
            ovr_r <= st_nxt == ST_RUN && !stuck_seen_r;
        end
    end

    assign coil_drive_en = coil_r;
    assign probe_osc_en = osc_r;
    assign degauss_active = deg_r;
    assign overload_recover_en = ovr_r;
    assign fault_n_o = 1'b0;
    assign fault_n_oe = fault_r;
    assign clip_n_o = 1'b0;
    assign clip_n_oe = clip_r;

    // ------------------------------
    // checker helpers
    // ------------------------------
    // run lengths counted apart from the filters, so a broken filter shows
    logic [CNT_W-1:0] over_run_r, req_hi_r, req_lo_r, deg_run_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            over_run_r <= '0;
        end else if (!over) begin
            over_run_r <= '0;
        end else if (over_run_r < CNT_W'(CLIP_CYC)) begin
            over_run_r <= over_run_r + 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_hi_r <= '0;
        end else if (!req) begin
            req_hi_r <= '0;
        end else if (req_hi_r < CNT_W'(REQ_ON_CYC)) begin
            req_hi_r <= req_hi_r + 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_lo_r <= '0;
        end else if (req) begin
            req_lo_r <= '0;
        end else if (req_lo_r < CNT_W'(REQ_OFF_CYC)) begin
            req_lo_r <= req_lo_r + 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            deg_run_r <= '0;
        end else if (!degauss_active) begin
            deg_run_r <= '0;
        end else if (deg_run_r < CNT_W'(DEG_CYC)) begin
            deg_run_r <= deg_run_r + 1'b1;
        end
    end

    // ------------------------------
    // checks
    // ------------------------------
    clip_delay_a: assert property (@(posedge clk) disable iff (rst)
        $rose(clip_n_oe) |-> over_run_r >= CNT_W'(CLIP_CYC))
        else $error("clip flag before over-range settled");
    clip_release_a: assert property (@(posedge clk) disable iff (rst)
        !over |=> !clip_n_oe) else $error("clip flag not released");
    deg_fault_a: assert property (@(posedge clk) disable iff (rst)
        degauss_active |-> fault_n_oe) else $error("fault flag high in degauss");
    deg_osc_a: assert property (@(posedge clk) disable iff (rst)
        degauss_active |-> probe_osc_en) else $error("oscillator stopped in degauss");
    abort_hold_a: assert property (@(posedge clk) disable iff (rst)
        (st_r == ST_DEG && st_nxt == ST_HOLD) |=> !coil_drive_en [*8])
        else $error("coil drive on after abort");
    dead_fault_a: assert property (@(posedge clk) disable iff (rst)
        probe_dead_r |=> fault_n_oe) else $error("dead probe not flagged");
    crit_reset_a: assert property (@(posedge clk) disable iff (rst)
        sup_crit |=> st_r == ST_OFF ##1 fault_n_oe) else $error("no reset on critical dip");
    run_coil_a: assert property (@(posedge clk) disable iff (rst)
        $rose(st_r == ST_RUN) |-> $past(good_r) >= 3'(PROBE_GOOD_CYCLES))
        else $error("run without good probe cycles");
    stuck_ovr_a: assert property (@(posedge clk) disable iff (rst)
        stuck_seen_r |=> !overload_recover_en) else $error("recovery after interruption");
    clip_set_a: assert property (@(posedge clk) disable iff (rst)
        over && over_run_r >= CNT_W'(CLIP_CYC) |=> clip_n_oe)
        else $error("clip flag late");
    deg_start_a: assert property (@(posedge clk) disable iff (rst)
        $rose(degauss_active) && $past(st_r) != ST_PUP |-> req_hi_r >= CNT_W'(REQ_ON_CYC))
        else $error("degauss on short request");
    abort_filter_a: assert property (@(posedge clk) disable iff (rst)
        st_r == ST_HOLD && $past(st_r) == ST_DEG |-> req_lo_r >= CNT_W'(REQ_OFF_CYC))
        else $error("degauss aborted by glitch");
    deg_length_a: assert property (@(posedge clk) disable iff (rst)
        st_r == ST_PROBE && $past(st_r) == ST_DEG |-> deg_run_r >= CNT_W'(DEG_CYC))
        else $error("degauss cycle cut short");
    ready_flag_a: assert property (@(posedge clk) disable iff (rst)
        !fault_n_oe |-> st_r == ST_RUN)
        else $error("fault flag released early");
    coil_state_a: assert property (@(posedge clk) disable iff (rst)
        coil_drive_en |-> st_r == ST_RUN || st_r == ST_DEG)
        else $error("coil drive on when not ready");
    run_c: cover property (@(posedge clk) disable iff (rst) $rose(st_r == ST_RUN));
    deg_c: cover property (@(posedge clk) disable iff (rst) $rose(degauss_active));
    abort_c: cover property (@(posedge clk) disable iff (rst) st_r == ST_HOLD);
    clip_c: cover property (@(posedge clk) disable iff (rst) $rose(clip_n_oe));
endmodule
`default_nettype wire

// >>> verification/probe_model.sv
`timescale 1ns/1ns
`default_nettype none
module probe_model #(
    parameter int HALF = 100
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // oscillator enable from the device, fault injection from the bench
    input wire logic osc_en,
    input wire logic alive,
    // comparator seen by the device
    output logic probe_cmp
);
    int cnt_r;
    // a broken probe never trips its comparator, so the line rests low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 0;
            probe_cmp <= 1'b0;
        end else if (!osc_en || !alive) begin
            cnt_r <= 0;
            probe_cmp <= 1'b0;
        end else if (cnt_r == HALF - 1) begin
            cnt_r <= 0;
            probe_cmp <= ~probe_cmp;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import seq_pkg::*;
;
    localparam int HALF = 100;
    logic clk = 1'b0, rst = 1'b1, demag_req = 1'b0, supply_ok = 1'b0;
    logic supply_crit = 1'b0, amp_nl = 1'b0, alive = 1'b1;
    logic coil_drive_en, probe_osc_en, degauss_active, overload_recover_en;
    logic fault_n_o, fault_n_oe, clip_n_o, clip_n_oe, probe_cmp;
    int num_errors = 0, compares = 0, ticks = 0;
    // open-drain flags with their pull-ups
    wire fault_n = fault_n_oe ? fault_n_o : 1'b1;
    wire clip_n = clip_n_oe ? clip_n_o : 1'b1;
    always #4 clk = ~clk;
    degauss_powerup_fault_sequencer dut (.clk(clk), .rst(rst), .demag_req(demag_req),
        .main_supply_ok(supply_ok), .main_supply_crit(supply_crit), .probe_cmp(probe_cmp),
        .amp_not_linear(amp_nl), .coil_drive_en(coil_drive_en), .probe_osc_en(probe_osc_en),
        .degauss_active(degauss_active), .overload_recover_en(overload_recover_en),
        .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .clip_n_o(clip_n_o),
        .clip_n_oe(clip_n_oe));
    probe_model #(.HALF(HALF)) probe (.clk(clk), .rst(rst), .osc_en(probe_osc_en),
        .alive(alive), .probe_cmp(probe_cmp));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // whole run needs about 67k cycles
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 100000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic power_up(input logic dm);
        rst = 1'b1;
        supply_ok = 1'b0;
        demag_req = dm;
        cyc(4);
        rst = 1'b0;
        cyc(4);
        supply_ok = 1'b1;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_run_up();
        power_up(1'b0);
        cyc(PUP_RUN_CYC - 100);
        chk(fault_n, 1'b0);
        chk(coil_drive_en, 1'b0);
        cyc(200);
        chk(fault_n, 1'b0);
        cyc(8 * HALF + 200);
        chk(fault_n, 1'b1);
        chk(coil_drive_en, 1'b1);
        chk(degauss_active, 1'b0);
        chk(overload_recover_en, 1'b1);
    endtask
    task automatic t_clip();
        amp_nl = 1'b1;
        cyc(300);
        chk(clip_n, 1'b1);
        amp_nl = 1'b0;
        cyc(10);
        amp_nl = 1'b1;
        cyc(CLIP_CYC - 10);
        chk(clip_n, 1'b1);
        cyc(20);
        chk(clip_n, 1'b0);
        chk(fault_n, 1'b1);
        amp_nl = 1'b0;
        cyc(5);
        chk(clip_n, 1'b1);
    endtask
    task automatic t_demag();
        demag_req = 1'b1;
        cyc(REQ_ON_CYC - 200);
        demag_req = 1'b0;
        cyc(REQ_OFF_CYC + 50);
        chk(degauss_active, 1'b0);
        demag_req = 1'b1;
        cyc(REQ_ON_CYC + 20);
        chk(degauss_active, 1'b1);
        chk(fault_n, 1'b0);
        chk(probe_osc_en, 1'b1);
        demag_req = 1'b0;
        cyc(REQ_OFF_CYC - 200);
        demag_req = 1'b1;
        cyc(10);
        chk(degauss_active, 1'b1);
        demag_req = 1'b0;
        cyc(REQ_OFF_CYC + 20);
        chk(degauss_active, 1'b0);
        cyc(1000);
        chk(fault_n, 1'b0);
        chk(coil_drive_en, 1'b0);
    endtask
    task automatic t_dip();
        supply_ok = 1'b0;
        cyc(DIP_CYC - 2000);
        chk(fault_n, 1'b1);
        supply_ok = 1'b1;
        cyc(20);
        chk(coil_drive_en, 1'b1);
        supply_ok = 1'b0;
        cyc(DIP_CYC + 100);
        chk(fault_n, 1'b0);
        chk(coil_drive_en, 1'b0);
        chk(probe_osc_en, 1'b0);
        demag_req = 1'b1;
        cyc(100);
        supply_ok = 1'b1;
        cyc(PUP_DEG_CYC - 50);
        chk(degauss_active, 1'b0);
        cyc(100);
        chk(degauss_active, 1'b1);
    endtask
    task automatic t_stuck();
        alive = 1'b0;
        cyc(HALF_MAX_CYC - 200);
        chk(fault_n, 1'b1);
        cyc(400);
        chk(fault_n, 1'b0);
        chk(coil_drive_en, 1'b0);
        alive = 1'b1;
        cyc(HALF + 200);
        chk(fault_n, 1'b0);
        chk(coil_drive_en, 1'b0);
        chk(overload_recover_en, 1'b0);
    endtask
    task automatic t_crit();
        supply_crit = 1'b1;
        cyc(6);
        chk(fault_n, 1'b0);
        chk(coil_drive_en, 1'b0);
        supply_crit = 1'b0;
    endtask
    initial begin
        @(negedge clk);
        t_run_up();
        t_clip();
        t_demag();
        t_run_up();
        t_dip();
        t_run_up();
        t_stuck();
        t_run_up();
        t_crit();
        close_out();
    end
endmodule
`default_nettype wire
